// file: scrb_pkg.sv
// Package for the system-control remap, reset and PLL register slice
`default_nettype none
package scrb_pkg;

  localparam logic [31:0] SCRB_BASE_ADDR   = 32'h4004_8000;
  localparam logic [31:0] SCRB_VECSRC_ADDR = 32'h4004_8000;
  localparam logic [31:0] SCRB_PRST_ADDR   = 32'h4004_8004;
  localparam logic [31:0] SCRB_PLLCTL_ADDR = 32'h4004_8008;
  localparam logic [31:0] SCRB_PLLSTA_ADDR = 32'h4004_800C;

  localparam int          SCRB_VECSRC_W    = 2;
  localparam int          SCRB_PRST_W      = 4;
  localparam int          SCRB_PLLCTL_W    = 7;
  localparam int          SCRB_FEEDBACK_DIVIDER_LSB    = 0;
  localparam int          SCRB_FEEDBACK_DIVIDER_W      = 5;
  localparam int          SCRB_PSEL_LSB    = 5;
  localparam int          SCRB_PSEL_W      = 2;
  localparam int          SCRB_PRST_SPI_A  = 0;
  localparam int          SCRB_PRST_I2C    = 1;
  localparam int          SCRB_PRST_SPI_B  = 2;
  localparam int          SCRB_PRST_CAN    = 3;
  localparam int          SCRB_LOCK_BIT    = 0;

  localparam logic [1:0]  SCRB_VECSRC_RST  = 2'h2;
  localparam logic [3:0]  SCRB_PRST_RST    = 4'h0;
  localparam logic [6:0]  SCRB_PLLCTL_RST  = 7'h00;

  // Remap window: lowest 512 bytes
  localparam int          SCRB_REMAP_BYTES = 512;
  localparam int          SCRB_REMAP_AW    = 9;
  localparam int          SCRB_FETCH_AW    = 32;

  typedef enum logic [1:0] {
    SCRB_SRC_BOOTROM = 2'h0,
    SCRB_SRC_SRAM    = 2'h1,
    SCRB_SRC_FLASH   = 2'h2
  } scrb_vecsrc_t;

  // One-hot memory target of a fetch
  typedef enum logic [2:0] {
    SCRB_TGT_FLASH   = 3'h1,
    SCRB_TGT_BOOTROM = 3'h2,
    SCRB_TGT_SRAM    = 3'h4
  } scrb_target_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } scrb_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } scrb_ahb_rsp_t;

  typedef struct packed {
    logic [4:0] feedback_divider;
    logic [5:0] pll_m_ratio;
    logic [4:0] pll_post_ratio;
  } scrb_pll_cfg_t;

  localparam scrb_pll_cfg_t SCRB_PLLCFG_RST = '{5'h00, 6'h01, 5'h02};

  localparam logic [1:0] SCRB_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] SCRB_HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] SCRB_HSIZE_WORD    = 3'h2;

endpackage
`default_nettype wire

// file: scrb_sync2.sv
// Two-stage synchroniser for a level from another domain
`timescale 1ns/1ps
`default_nettype none
module scrb_sync2 (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic meta_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// file: scrb_regs.sv
// System-control remap, peripheral reset and PLL register slice
`timescale 1ns/1ps
`default_nettype none
module scrb_regs
  import scrb_pkg::*;
#(
  parameter int FETCH_AW = SCRB_FETCH_AW
) (
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  input  wire scrb_ahb_req_t ahb_req,
  output var  scrb_ahb_rsp_t ahb_rsp,
  input  wire logic [31:0]   fetch_addr,
  input  wire logic          pll_lock_raw,
  output var  scrb_target_t  fetch_target,
  output var  logic [31:0]   fetch_addr_out,
  output var  logic          spi_a_reset_n,
  output var  logic          i2c_reset_n,
  output var  logic          spi_b_reset_n,
  output var  logic          can_reset_n,
  output var  scrb_pll_cfg_t pll_cfg
);

  if (FETCH_AW != 32) begin : g_bad_aw
    $error("FETCH_AW must be 32");
  end

  typedef struct packed {
    logic         wr_pend;
    logic [1:0]   wr_idx;
    logic         rd_pend;
    logic [31:0]  rdata;
    logic [1:0]   vecsrc;
    logic [3:0]   prst;
    logic [6:0]   pllctl;
    scrb_target_t target;
    logic [31:0]  faddr;
    scrb_pll_cfg_t cfg;
  } scrb_state_t;

  scrb_state_t st_q;
  scrb_state_t st_d;
  logic        lock_sync;

  // Lock crosses from the analog PLL domain
  scrb_sync2 u_lock_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in (pll_lock_raw),
    .sync_out (lock_sync)
  );

  function automatic logic hit(input logic [31:0] a, output logic [1:0] idx);
    idx = a[3:2];
    return (a[31:4] == SCRB_BASE_ADDR[31:4]);
  endfunction

  function automatic logic [31:0] read_word(input logic [1:0] idx,
                                            input scrb_state_t s,
                                            input logic lk);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      2'h0: w[SCRB_VECSRC_W-1:0] = s.vecsrc;
      2'h1: w[SCRB_PRST_W-1:0] = s.prst;
      2'h2: w[SCRB_PLLCTL_W-1:0] = s.pllctl;
      2'h3: w[SCRB_LOCK_BIT] = lk;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Lowest 512 bytes are steered by the vector source
  function automatic scrb_target_t route(input logic [31:0] a,
                                         input logic [1:0] src);
    scrb_target_t t;
    t = SCRB_TGT_FLASH;
    if (a[31:SCRB_REMAP_AW] == '0) begin
      case (src)
        SCRB_SRC_BOOTROM: t = SCRB_TGT_BOOTROM;
        SCRB_SRC_SRAM:    t = SCRB_TGT_SRAM;
        SCRB_SRC_FLASH:   t = SCRB_TGT_FLASH;
        default:          t = SCRB_TGT_FLASH;
      endcase
    end
    return t;
  endfunction

  function automatic logic [4:0] post_ratio(input logic [1:0] p);
    logic [4:0] r;
    r = 5'h02;
    case (p)
      2'h0: r = 5'h02;
      2'h1: r = 5'h04;
      2'h2: r = 5'h08;
      2'h3: r = 5'h10;
      default: r = 5'h02;
    endcase
    return r;
  endfunction

  logic       a_hit;
  logic [1:0] a_idx;
  logic       a_valid;

  always_comb begin
    st_d = st_q;
    a_hit = hit(ahb_req.haddr, a_idx);
    a_valid = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
    st_d.wr_pend = 1'b0;
    st_d.rd_pend = 1'b0;
    // Write data lands one edge after its address phase
    if (st_q.wr_pend) begin
      case (st_q.wr_idx)
        2'h0: st_d.vecsrc = ahb_req.hwdata[SCRB_VECSRC_W-1:0];
        2'h1: st_d.prst = ahb_req.hwdata[SCRB_PRST_W-1:0];
        2'h2: st_d.pllctl = ahb_req.hwdata[SCRB_PLLCTL_W-1:0];
        default: st_d.prst = st_q.prst;
      endcase
    end
    if (a_valid && a_hit) begin
      st_d.wr_pend = ahb_req.hwrite;
      st_d.wr_idx  = a_idx;
      st_d.rd_pend = !ahb_req.hwrite;
    end
    st_d.rdata = (a_valid && a_hit && !ahb_req.hwrite) ?
                 read_word(a_idx, st_q, lock_sync) : 32'h0000_0000;
    st_d.target = route(fetch_addr, st_q.vecsrc);
    st_d.faddr = fetch_addr;
    st_d.cfg.feedback_divider = st_d.pllctl[SCRB_FEEDBACK_DIVIDER_LSB+:SCRB_FEEDBACK_DIVIDER_W];
    st_d.cfg.pll_m_ratio =
      {1'b0, st_d.pllctl[SCRB_FEEDBACK_DIVIDER_LSB+:SCRB_FEEDBACK_DIVIDER_W]} + 6'h01;
    st_d.cfg.pll_post_ratio =
      post_ratio(st_d.pllctl[SCRB_PSEL_LSB+:SCRB_PSEL_W]);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q.wr_pend <= 1'b0;
      st_q.wr_idx  <= 2'h0;
      st_q.rd_pend <= 1'b0;
      st_q.rdata   <= 32'h0000_0000;
      st_q.vecsrc  <= SCRB_VECSRC_RST;
      st_q.prst    <= SCRB_PRST_RST;
      st_q.pllctl  <= SCRB_PLLCTL_RST;
      st_q.target  <= SCRB_TGT_FLASH;
      st_q.faddr   <= 32'h0000_0000;
      st_q.cfg     <= SCRB_PLLCFG_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign ahb_rsp.hrdata    = st_q.rdata;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp     = 1'b0;
  assign fetch_target      = st_q.target;
  assign fetch_addr_out    = st_q.faddr;
  assign spi_a_reset_n     = st_q.prst[SCRB_PRST_SPI_A];
  assign i2c_reset_n       = st_q.prst[SCRB_PRST_I2C];
  assign spi_b_reset_n     = st_q.prst[SCRB_PRST_SPI_B];
  assign can_reset_n       = st_q.prst[SCRB_PRST_CAN];
  assign pll_cfg           = st_q.cfg;

  sequence s_wr_prst;
    ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && ahb_req.hwrite
      && ahb_req.haddr == SCRB_PRST_ADDR;
  endsequence

  sequence s_wr_vec;
    ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && ahb_req.hwrite
      && ahb_req.haddr == SCRB_VECSRC_ADDR;
  endsequence

  sequence s_wr_pll;
    ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && ahb_req.hwrite
      && ahb_req.haddr == SCRB_PLLCTL_ADDR;
  endsequence

  sequence s_wr_sta;
    ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && ahb_req.hwrite
      && ahb_req.haddr == SCRB_PLLSTA_ADDR;
  endsequence

  sequence s_rd_any;
    ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && !ahb_req.hwrite;
  endsequence

  a_prst_zero_holds: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_prst ##1 !ahb_req.hwdata[SCRB_PRST_SPI_A] |=> !spi_a_reset_n)
    else $error("spi_a reset not asserted after zero write");

  a_prst_one_release: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_prst ##1 ahb_req.hwdata[SCRB_PRST_CAN] |=> can_reset_n)
    else $error("can reset not released after one write");

  a_prst_sticks: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !$past(st_q.wr_pend) |-> $stable(st_q.prst))
    else $error("reset bits changed without a write");

  a_vec_flash_map: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    st_q.vecsrc == SCRB_SRC_FLASH ##1 1'b1 |-> fetch_target == SCRB_TGT_FLASH
      || $past(st_q.vecsrc) != SCRB_SRC_FLASH)
    else $error("flash mode routed fetch away from flash");

  a_vec_boot_map: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    st_q.vecsrc == SCRB_SRC_BOOTROM && fetch_addr < SCRB_REMAP_BYTES
      |=> fetch_target == SCRB_TGT_BOOTROM)
    else $error("boot mode fetch not sent to boot ROM");

  a_vec_sram_map: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    st_q.vecsrc == SCRB_SRC_SRAM && fetch_addr < SCRB_REMAP_BYTES
      |=> fetch_target == SCRB_TGT_SRAM)
    else $error("RAM mode fetch not sent to SRAM");

  a_high_unmapped: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    fetch_addr >= SCRB_REMAP_BYTES |=> fetch_target == SCRB_TGT_FLASH)
    else $error("address above 512 bytes was remapped");

  a_m_ratio: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    pll_cfg.pll_m_ratio == {1'b0, pll_cfg.feedback_divider} + 6'h01)
    else $error("feedback ratio is not field plus one");

  a_vec_write: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_vec ##1 1'b1 |=> st_q.vecsrc == $past(ahb_req.hwdata[1:0]))
    else $error("vector source write not stored");

  a_lock_read: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && !ahb_req.hwrite
      && ahb_req.haddr == SCRB_PLLSTA_ADDR
      |=> ahb_rsp.hrdata == {31'h0, $past(lock_sync)})
    else $error("status read does not show lock alone");

  a_pll_hold: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    pll_lock_raw [*3] |-> ##1 lock_sync)
    else $error("lock not seen after synchroniser delay");

  // Peripheral reset bits, one per controller
  a_spi_b_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_prst ##1 !ahb_req.hwdata[SCRB_PRST_SPI_B] |=> !spi_b_reset_n)
    else $error("spi_b reset not asserted after zero write");

  a_i2c_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_prst ##1 !ahb_req.hwdata[SCRB_PRST_I2C] |=> !i2c_reset_n)
    else $error("i2c reset not asserted after zero write");

  a_can_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_prst ##1 !ahb_req.hwdata[SCRB_PRST_CAN] |=> !can_reset_n)
    else $error("can reset not asserted after zero write");

  a_spi_a_release: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_prst ##1 ahb_req.hwdata[SCRB_PRST_SPI_A] |=> spi_a_reset_n)
    else $error("spi_a reset not released after one write");

  a_i2c_release: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_prst ##1 ahb_req.hwdata[SCRB_PRST_I2C] |=> i2c_reset_n)
    else $error("i2c reset not released after one write");

  a_spi_b_release: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_prst ##1 ahb_req.hwdata[SCRB_PRST_SPI_B] |=> spi_b_reset_n)
    else $error("spi_b reset not released after one write");

  // PLL divider fields
  a_pll_fb_write: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_pll ##1 1'b1 |=> pll_cfg.feedback_divider
      == $past(ahb_req.hwdata[SCRB_FEEDBACK_DIVIDER_LSB+:SCRB_FEEDBACK_DIVIDER_W]))
    else $error("feedback divider write not applied");

  a_m_ratio_one: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_pll ##1 ahb_req.hwdata[4:0] == 5'h00 |=> pll_cfg.pll_m_ratio == 6'h01)
    else $error("feedback ratio not 1 for field 0");

  a_m_ratio_top: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_pll ##1 ahb_req.hwdata[4:0] == 5'h1F |=> pll_cfg.pll_m_ratio == 6'h20)
    else $error("feedback ratio not 32 for field 31");

  a_post_div_one: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_pll ##1 ahb_req.hwdata[6:5] == 2'h0 |=> pll_cfg.pll_post_ratio == 5'h02)
    else $error("post ratio not 2 for code 0");

  a_post_div_two: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_pll ##1 ahb_req.hwdata[6:5] == 2'h1 |=> pll_cfg.pll_post_ratio == 5'h04)
    else $error("post ratio not 4 for code 1");

  a_post_div_four: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_pll ##1 ahb_req.hwdata[6:5] == 2'h2 |=> pll_cfg.pll_post_ratio == 5'h08)
    else $error("post ratio not 8 for code 2");

  a_post_div_eight: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_pll ##1 ahb_req.hwdata[6:5] == 2'h3 |=> pll_cfg.pll_post_ratio == 5'h10)
    else $error("post ratio not 16 for code 3");

  // Read side, status and fetch address pass-through
  a_status_ro: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_wr_sta ##1 1'b1 |=> $stable(st_q.vecsrc) && $stable(st_q.prst)
      && $stable(st_q.pllctl))
    else $error("status write changed a register");

  a_rsvd_read_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_rd_any |=> ahb_rsp.hrdata[31:SCRB_PLLCTL_W] == '0)
    else $error("reserved read bits not zero");

  a_unmapped_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_rd_any && ahb_req.haddr[31:4] != SCRB_BASE_ADDR[31:4]
      |=> ahb_rsp.hrdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  a_lock_drop: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !pll_lock_raw [*3] |-> ##1 !lock_sync)
    else $error("lock loss not seen after synchroniser delay");

  a_fetch_pass: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    1'b1 |=> fetch_addr_out == $past(fetch_addr))
    else $error("fetch address not passed through");

endmodule
`default_nettype wire

// file: scrb_tb.sv
// Self-checking bench for the remap, peripheral reset and PLL register slice
`timescale 1ns/1ps
`default_nettype none
module sysctl_remap_reset_pll_regs_tb_top
  import scrb_pkg::*;
;
  logic          sys_clk;
  logic          reset_n;
  logic          hsel;
  logic          hwrite;
  logic          lock_raw;
  logic [1:0]    htrans;
  logic [31:0]   haddr;
  logic [31:0]   hwdata;
  logic [31:0]   fetch_addr;
  logic [31:0]   fa_out;
  logic [31:0]   rdat;
  logic          spi_a;
  logic          i2c;
  logic          spi_b;
  logic          can;
  scrb_ahb_req_t req;
  scrb_ahb_rsp_t rsp;
  scrb_target_t  tgt;
  scrb_pll_cfg_t cfg;
  int            errors;
  int            compares;
  int            vec_m;
  int            prst_m;
  int            pll_m;
  logic [31:0]   w;
  logic [31:0]   fa_list [$];
  logic [31:0]   pll_list [$];

  assign req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
                 hsize: SCRB_HSIZE_WORD, hwdata: hwdata,
                 hready: rsp.hreadyout};

  scrb_regs dut (
    .sys_clk        (sys_clk),
    .reset_n        (reset_n),
    .ahb_req        (req),
    .ahb_rsp        (rsp),
    .fetch_addr     (fetch_addr),
    .pll_lock_raw   (lock_raw),
    .fetch_target   (tgt),
    .fetch_addr_out (fa_out),
    .spi_a_reset_n  (spi_a),
    .i2c_reset_n    (i2c),
    .spi_b_reset_n  (spi_b),
    .can_reset_n    (can),
    .pll_cfg        (cfg)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic test_done();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single AHB transfer; data phase value sampled at the falling edge before the accepting edge
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    logic rdy;
    logic err;
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= SCRB_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do begin
      @(negedge sys_clk);
      rdy = rsp.hreadyout;
      @(posedge sys_clk);
    end while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge sys_clk);
      rdy = rsp.hreadyout;
      rd = rsp.hrdata;
      err = rsp.hresp;
      @(posedge sys_clk);
    end while (rdy !== 1'b1);
    chk({31'h0, err}, 32'h0);
  endtask

  task automatic rd_chk(input logic [31:0] a, input int exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d, 32'(exp));
  endtask

  task automatic outs_chk();
    logic [4:0]  fb;
    logic [15:0] ec;
    @(negedge sys_clk);
    fb = 5'(pll_m);
    ec = {fb, 6'(fb + 6'h1), 5'(2 << (pll_m >> 5))};
    chk({28'h0, can, spi_b, i2c, spi_a}, 32'(prst_m));
    chk({16'h0, cfg}, {16'h0, ec});
  endtask

  task automatic fetch_chk(input logic [31:0] a);
    logic [2:0] e;
    e = (a >= 32'h200 || vec_m >= 2) ? 3'h1 : (vec_m == 0 ? 3'h2 : 3'h4);
    @(posedge sys_clk);
    fetch_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({29'h0, tgt}, {29'h0, e});
    chk(fa_out, a);
  endtask

  initial begin
    #200us;
    errors++;
    test_done();
  end

  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    fetch_addr = 32'h0;
    lock_raw = 1'b0;
    errors = 0;
    compares = 0;
    vec_m = 2;
    prst_m = 0;
    pll_m = 0;
    w = $urandom(32'h71ED1F85);
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    outs_chk();
    rd_chk(SCRB_VECSRC_ADDR, 2);
    rd_chk(SCRB_PRST_ADDR, 0);
    rd_chk(SCRB_PLLCTL_ADDR, 0);
    rd_chk(SCRB_PLLSTA_ADDR, 0);
    fetch_chk(32'h0);
    for (int v = 0; v < 4; v++) begin
      bus(1'b1, SCRB_VECSRC_ADDR, ($urandom & 32'hFFFF_FFFC) | 32'(v), rdat);
      vec_m = v;
      rd_chk(SCRB_VECSRC_ADDR, v);
      fa_list = {32'h0, 32'h1FF, $urandom % 32'h200, 32'h200};
      foreach (fa_list[i]) fetch_chk(fa_list[i]);
      fetch_chk(32'h200 + $urandom % 32'hFFFF);
    end
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 32'hFFFF_FFFF : (i == 1 ? 32'h0 : $urandom);
      bus(1'b1, SCRB_PRST_ADDR, w, rdat);
      prst_m = int'(w & 32'hF);
      outs_chk();
      rd_chk(SCRB_PRST_ADDR, prst_m);
    end
    pll_list = {32'h7F, 32'h00, 32'h25, 32'h4A};
    for (int i = 0; i < 12; i++) begin
      w = (i < 4) ? pll_list[i] : ($urandom & 32'h7F);
      bus(1'b1, SCRB_PLLCTL_ADDR, w, rdat);
      pll_m = int'(w);
      outs_chk();
      rd_chk(SCRB_PLLCTL_ADDR, pll_m);
    end
    @(posedge sys_clk);
    lock_raw <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_chk(SCRB_PLLSTA_ADDR, 1);
    bus(1'b1, SCRB_PLLSTA_ADDR, 32'h0, rdat);
    rd_chk(SCRB_PLLSTA_ADDR, 1);
    @(posedge sys_clk);
    lock_raw <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd_chk(SCRB_PLLSTA_ADDR, 0);
    bus(1'b1, SCRB_BASE_ADDR + 32'h10, 32'hFFFF_FFFF, rdat);
    rd_chk(SCRB_BASE_ADDR + 32'h10, 0);
    rd_chk(SCRB_VECSRC_ADDR, vec_m);
    outs_chk();
    test_done();
  end
endmodule
`default_nettype wire
